// file: common/seep_pkg.sv
// Shared constants and types of the serial EEPROM read and busy-poll target
`default_nettype none
package seep_pkg;
	localparam logic [3:0] SEL_TYPE = 4'ha;
	localparam int SEL_RW_BIT = 0;
	localparam int SEL_CS_LSB = 1;
	localparam int SEL_TYPE_LSB = 4;
	localparam int BYTE_W = 8;
	localparam int ADDR_W_DEF = 16;
	localparam int FIFO_DEPTH = 4;
	localparam logic [7:0] ERASED_BYTE = 8'hff;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [3:0] ACK_SEEN = 4'h9;
	localparam logic [1:0] IDX_SEL = 2'h0;
	localparam logic [1:0] IDX_AHI = 2'h1;
	localparam logic [1:0] IDX_ALO = 2'h2;
	localparam logic [1:0] IDX_DATA = 2'h3;
	localparam int MCLK_MHZ = 250;
	localparam int PROG_TIME_NS_DEF = 5000000;
	typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_RX_ACK, ST_TX, ST_TX_ACK, ST_DRAIN} seep_state_t;
endpackage : seep_pkg
`default_nettype wire

// file: rtl/seep_top.sv
// Serial EEPROM target: select decode, reads, busy polling and write buffer
`timescale 1ns/1ps
`default_nettype none

module seep_fifo #(
	parameter int W = 8,
	parameter int D = 4
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic flush,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	localparam int PW = (D > 1) ? $clog2(D) : 1;
	localparam int CW = $clog2(D + 1);
	localparam logic [PW-1:0] LAST = PW'(D - 1);
	localparam logic [CW-1:0] FULL = CW'(D);
	logic [W-1:0] store [0:D-1];
	logic [PW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
	logic [CW-1:0] cnt_r, cnt_nxt;
	logic push, pop;
	assign in_ready = (cnt_r != FULL);
	assign out_valid = (cnt_r != '0);
	assign out_data = store[rp_r];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	always_comb
	begin
		wp_nxt = push ? ((wp_r == LAST) ? '0 : wp_r + 1'b1) : wp_r;
		rp_nxt = pop ? ((rp_r == LAST) ? '0 : rp_r + 1'b1) : rp_r;
		cnt_nxt = cnt_r + CW'(push) - CW'(pop);
		if (flush)
		begin
			wp_nxt = '0;
			rp_nxt = '0;
			cnt_nxt = '0;
		end
	end
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
		end
		else
		begin
			wp_r <= wp_nxt;
			rp_r <= rp_nxt;
			cnt_r <= cnt_nxt;
		end
	end
	always_ff @(posedge clk)
	begin
		if (push)
			store[wp_r] <= in_data;
	end
endmodule : seep_fifo

module seep_top
	import seep_pkg::*;
#(
	parameter int ADDR_W = seep_pkg::ADDR_W_DEF,
	parameter int PROG_TIME_NS = seep_pkg::PROG_TIME_NS_DEF
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic ce,
	input wire logic link_clk,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe,
	input wire logic write_protect_input,
	input wire logic chip_select_strap_0,
	input wire logic chip_select_strap_1,
	input wire logic chip_select_strap_2,
	output logic write_busy
);
	import seep_pkg::*;
	localparam int DEPTH = 1 << ADDR_W;
	localparam int PROG_CYC_I = (PROG_TIME_NS * MCLK_MHZ + 999) / 1000;
	localparam logic [31:0] PROG_CYC = 32'((PROG_CYC_I < 1) ? 1 : PROG_CYC_I);

	// Pin synchronisers in the link domain
	logic [5:0] pin_m_r, pin_s_r;
	logic scl_p_r, sda_p_r;
	logic scl_s, sda_s, wp_s;
	logic [2:0] cs_s;
	always_ff @(posedge link_clk or posedge rst)
	begin
		if (rst)
		begin
			pin_m_r <= 6'h3;
			pin_s_r <= 6'h3;
			scl_p_r <= 1'b1;
			sda_p_r <= 1'b1;
		end
		else
		begin
			pin_m_r <= {chip_select_strap_2, chip_select_strap_1, chip_select_strap_0,
				write_protect_input, sda_i, scl_i};
			pin_s_r <= pin_m_r;
			scl_p_r <= pin_s_r[0];
			sda_p_r <= pin_s_r[1];
		end
	end
	assign scl_s = pin_s_r[0];
	assign sda_s = pin_s_r[1];
	assign wp_s = pin_s_r[2];
	assign cs_s = pin_s_r[5:3];

	logic start_ev, stop_ev, rise_ev, fall_ev;
	assign start_ev = scl_s && scl_p_r && sda_p_r && !sda_s;
	assign stop_ev = scl_s && scl_p_r && !sda_p_r && sda_s;
	assign rise_ev = !scl_p_r && scl_s;
	assign fall_ev = scl_p_r && !scl_s;

	// Array, erased at start
	logic [7:0] mem [0:DEPTH-1];
	initial
	begin
		for (int i = 0; i < DEPTH; i++)
			mem[i] = ERASED_BYTE;
	end

	seep_state_t st_r, st_nxt;
	logic [3:0] bit_r, bit_nxt;
	logic [1:0] idx_r, idx_nxt;
	logic [7:0] sr_r, sr_nxt, ahi_r, ahi_nxt;
	logic [ADDR_W-1:0] addr_r, addr_nxt;
	logic rw_r, rw_nxt, oe_r, oe_nxt, ackd_r, ackd_nxt;
	logic tgl_r, tgl_nxt, pend_r, pend_nxt;
	logic bsy_m_r, bsy_s_r, busy_w, sel_ok;
	logic f_flush, f_push, f_ready, f_valid, f_pop;
	logic [7:0] f_data, mem_rd;
	assign busy_w = (st_r == ST_DRAIN) || pend_r || bsy_s_r;
	assign sel_ok = (sr_r[7:SEL_TYPE_LSB] == SEL_TYPE) && (sr_r[SEL_TYPE_LSB-1:SEL_CS_LSB] == cs_s);
	assign mem_rd = mem[addr_r];

	seep_fifo #(.W(BYTE_W), .D(FIFO_DEPTH)) u_wbuf (
		.clk(link_clk),
		.rst(rst),
		.flush(f_flush),
		.in_valid(f_push),
		.in_ready(f_ready),
		.in_data(sr_r),
		.out_valid(f_valid),
		.out_ready(f_pop),
		.out_data(f_data)
	);

	always_comb
	begin
		st_nxt = st_r;
		bit_nxt = bit_r;
		idx_nxt = idx_r;
		sr_nxt = sr_r;
		ahi_nxt = ahi_r;
		addr_nxt = addr_r;
		rw_nxt = rw_r;
		oe_nxt = oe_r;
		ackd_nxt = ackd_r;
		tgl_nxt = tgl_r;
		pend_nxt = pend_r && !bsy_s_r;
		f_flush = 1'b0;
		f_push = 1'b0;
		f_pop = 1'b0;
		if (st_r == ST_DRAIN)
		begin
			f_pop = 1'b1;
			if (f_valid)
				addr_nxt = addr_r + 1'b1;
			else
			begin
				tgl_nxt = !tgl_r;
				pend_nxt = 1'b1;
				st_nxt = ST_IDLE;
			end
		end
		else if (stop_ev)
		begin
			oe_nxt = 1'b0;
			ackd_nxt = 1'b0;
			if (ackd_r && idx_r == IDX_DATA && f_valid)
				st_nxt = ST_DRAIN;
			else
			begin
				f_flush = 1'b1;
				st_nxt = ST_IDLE;
			end
		end
		else if (start_ev)
		begin
			oe_nxt = 1'b0;
			ackd_nxt = 1'b0;
			f_flush = 1'b1;
			bit_nxt = '0;
			idx_nxt = IDX_SEL;
			st_nxt = busy_w ? ST_IDLE : ST_RX;
		end
		else
		begin
			case (st_r)
				ST_RX:
				begin
					if (rise_ev)
					begin
						sr_nxt = {sr_r[6:0], sda_s};
						bit_nxt = bit_r + 1'b1;
						// Ack mark lives through the stop slot's own clock rise
						ackd_nxt = ackd_r && (bit_r == '0);
					end
					else if (fall_ev && bit_r == BITS_PER_BYTE)
					begin
						oe_nxt = 1'b1;
						st_nxt = ST_RX_ACK;
						case (idx_r)
							IDX_SEL:
							begin
								rw_nxt = sr_r[SEL_RW_BIT];
								if (!sel_ok)
								begin
									oe_nxt = 1'b0;
									st_nxt = ST_IDLE;
								end
							end
							IDX_AHI: ahi_nxt = sr_r;
							IDX_ALO: addr_nxt = ADDR_W'({ahi_r, sr_r});
							default:
							begin
								f_push = !wp_s;
								if (wp_s || !f_ready)
								begin
									oe_nxt = 1'b0;
									f_flush = 1'b1;
									st_nxt = ST_IDLE;
								end
							end
						endcase
					end
				end
				ST_RX_ACK:
				begin
					if (fall_ev)
					begin
						bit_nxt = '0;
						if (idx_r == IDX_SEL && rw_r)
						begin
							sr_nxt = mem_rd;
							oe_nxt = !mem_rd[7];
							st_nxt = ST_TX;
						end
						else
						begin
							oe_nxt = 1'b0;
							ackd_nxt = (idx_r == IDX_DATA);
							idx_nxt = (idx_r == IDX_DATA) ? IDX_DATA : idx_r + 1'b1;
							st_nxt = ST_RX;
						end
					end
				end
				ST_TX:
				begin
					if (rise_ev)
						bit_nxt = bit_r + 1'b1;
					else if (fall_ev)
					begin
						if (bit_r == BITS_PER_BYTE)
						begin
							oe_nxt = 1'b0;
							addr_nxt = addr_r + 1'b1;
							bit_nxt = '0;
							st_nxt = ST_TX_ACK;
						end
						else
						begin
							sr_nxt = {sr_r[6:0], 1'b1};
							oe_nxt = !sr_r[6];
						end
					end
				end
				ST_TX_ACK:
				begin
					if (rise_ev)
					begin
						if (sda_s)
							st_nxt = ST_IDLE;
						else
							bit_nxt = ACK_SEEN;
					end
					else if (fall_ev && bit_r == ACK_SEEN)
					begin
						sr_nxt = mem_rd;
						oe_nxt = !mem_rd[7];
						bit_nxt = '0;
						st_nxt = ST_TX;
					end
				end
				default: oe_nxt = 1'b0;
			endcase
		end
	end

	always_ff @(posedge link_clk or posedge rst)
	begin
		if (rst)
		begin
			st_r <= ST_IDLE;
			bit_r <= '0;
			idx_r <= IDX_SEL;
			sr_r <= '0;
			ahi_r <= '0;
			addr_r <= '0;
			rw_r <= 1'b0;
			oe_r <= 1'b0;
			ackd_r <= 1'b0;
			tgl_r <= 1'b0;
			pend_r <= 1'b0;
			bsy_m_r <= 1'b0;
			bsy_s_r <= 1'b0;
			sda_o <= 1'b0;
		end
		else
		begin
			st_r <= st_nxt;
			bit_r <= bit_nxt;
			idx_r <= idx_nxt;
			sr_r <= sr_nxt;
			ahi_r <= ahi_nxt;
			addr_r <= addr_nxt;
			rw_r <= rw_nxt;
			oe_r <= oe_nxt;
			ackd_r <= ackd_nxt;
			tgl_r <= tgl_nxt;
			pend_r <= pend_nxt;
			bsy_m_r <= write_busy;
			bsy_s_r <= bsy_m_r;
			sda_o <= 1'b0;
		end
	end
	assign sda_oe = oe_r;

	always_ff @(posedge link_clk)
	begin
		if (st_r == ST_DRAIN && f_valid)
			mem[addr_r] <= f_data;
	end

	// Write cycle timer in the core domain
	logic tgl_m_r, tgl_s_r, tgl_p_r, busy_nxt;
	logic [31:0] cnt_r, cnt_nxt;
	always_comb
	begin
		busy_nxt = write_busy;
		cnt_nxt = cnt_r;
		if (tgl_s_r != tgl_p_r)
		begin
			busy_nxt = 1'b1;
			cnt_nxt = PROG_CYC - 32'h1;
		end
		else if (write_busy)
		begin
			if (cnt_r == '0)
				busy_nxt = 1'b0;
			else
				cnt_nxt = cnt_r - 32'h1;
		end
	end
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			tgl_m_r <= 1'b0;
			tgl_s_r <= 1'b0;
			tgl_p_r <= 1'b0;
			write_busy <= 1'b0;
			cnt_r <= '0;
		end
		else if (ce)
		begin
			tgl_m_r <= tgl_r;
			tgl_s_r <= tgl_m_r;
			tgl_p_r <= tgl_s_r;
			write_busy <= busy_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	a_busy_no_ack: assert property (@(posedge link_clk) disable iff (rst)
		(start_ev && busy_w && st_r != ST_DRAIN) |=> st_r == ST_IDLE && !oe_r)
		else $error("busy device answered a start");
	a_sel_match_ack: assert property (@(posedge link_clk) disable iff (rst)
		(st_r == ST_RX && !start_ev && !stop_ev && fall_ev && bit_r == BITS_PER_BYTE
		&& idx_r == IDX_SEL && sel_ok) |=> st_r == ST_RX_ACK && oe_r)
		else $error("matching select not acknowledged");
	a_sel_miss_idle: assert property (@(posedge link_clk) disable iff (rst)
		(st_r == ST_RX && !start_ev && !stop_ev && fall_ev && bit_r == BITS_PER_BYTE
		&& idx_r == IDX_SEL && !sel_ok) |=> st_r == ST_IDLE && !oe_r)
		else $error("foreign select acknowledged");
	a_read_any_wp: assert property (@(posedge link_clk) disable iff (rst)
		(st_r == ST_RX_ACK && !start_ev && !stop_ev && fall_ev && idx_r == IDX_SEL && rw_r)
		|=> st_r == ST_TX && sr_r == $past(mem_rd))
		else $error("read not started after select");
	a_addr_advance: assert property (@(posedge link_clk) disable iff (rst)
		(st_r == ST_TX && !start_ev && !stop_ev && fall_ev && bit_r == BITS_PER_BYTE)
		|=> addr_r == ADDR_W'($past(addr_r) + 1'b1) ##1 st_r == ST_TX_ACK || st_r == ST_IDLE)
		else $error("address counter did not advance");
	a_nack_standby: assert property (@(posedge link_clk) disable iff (rst)
		(st_r == ST_TX_ACK && !start_ev && !stop_ev && rise_ev && sda_s)
		|=> st_r == ST_IDLE && !oe_r)
		else $error("transmit kept after master nack");
	a_stop_no_cycle: assert property (@(posedge link_clk) disable iff (rst)
		(stop_ev && st_r != ST_DRAIN && !(ackd_r && idx_r == IDX_DATA && f_valid))
		|=> st_r == ST_IDLE && $stable(tgl_r))
		else $error("write cycle started by misplaced stop");
	a_ack_release: assert property (@(posedge link_clk) disable iff (rst)
		(st_r == ST_TX_ACK) |-> !oe_r)
		else $error("data line held in master ack slot");
	a_busy_holds: assert property (@(posedge mclk) disable iff (rst)
		$rose(write_busy) && PROG_CYC > 32'h2 |=> write_busy [*2])
		else $error("write cycle ended too early");
	c_random_read: cover property (@(posedge link_clk) disable iff (rst)
		st_r == ST_RX_ACK && idx_r == IDX_SEL && rw_r && ahi_r != '0);
	c_seq_read: cover property (@(posedge link_clk) disable iff (rst)
		st_r == ST_TX_ACK && bit_r == ACK_SEEN);
	c_drain: cover property (@(posedge link_clk) disable iff (rst) st_r == ST_DRAIN);
	c_poll_busy: cover property (@(posedge link_clk) disable iff (rst) start_ev && busy_w);
endmodule : seep_top
`default_nettype wire

// file: dv/seep_bus_master.sv
// Two-wire bus master model: bus clock and open-drain data pull
`timescale 1ns/1ps
`default_nettype none
module seep_bus_master (
	input wire logic link_clk,
	input wire logic sda,
	output logic scl,
	output logic sda_pull
);
	initial
	begin
		scl = 1'b1;
		sda_pull = 1'b0;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge link_clk);
	endtask : tick

	// Data moves only while the clock is low; sampled mid high phase
	task automatic bit_x(input logic b, output logic r);
		tick(1);
		sda_pull <= ~b;
		tick(7);
		scl <= 1'b1;
		tick(3);
		r = sda;
		tick(3);
		scl <= 1'b0;
		tick(6);
	endtask : bit_x

	// Byte out MSB first, then the ninth slot
	task automatic xfer(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx,
		output logic ack_out);
		logic r;
		for (int i = 7; i >= 0; i--)
		begin
			bit_x(tx[i], r);
			rx[i] = r;
		end
		bit_x(ack_in, ack_out);
	endtask : xfer

	// Start or repeated start
	task automatic start;
		@(posedge link_clk) sda_pull <= 1'b0;
		tick(4);
		scl <= 1'b1;
		tick(6);
		sda_pull <= 1'b1;
		tick(6);
		scl <= 1'b0;
	endtask : start

	task automatic stop;
		@(posedge link_clk) sda_pull <= 1'b1;
		tick(4);
		scl <= 1'b1;
		tick(6);
		sda_pull <= 1'b0;
		tick(8);
	endtask : stop
endmodule : seep_bus_master
`default_nettype wire

// file: dv/tb_serial_eeprom_read_and_busy_poll.sv
// Self-checking bench of the serial EEPROM target
`timescale 1ns/1ps
`default_nettype none
module tb_serial_eeprom_read_and_busy_poll;
	import seep_pkg::*;
	localparam int AW = 4;
	localparam int SIZE = 2 ** AW;
	logic mclk, link_clk, rst, ce, wp, sda_o, sda_oe, write_busy, scl, pull, sda, ack;
	logic [2:0] strap;
	logic [7:0] mem_exp [SIZE];
	logic [7:0] rx, d, bad;
	int err_count, total_checks, ptr, a, n;

	// Wired-AND data line with pull-up
	assign sda = ~(pull | (sda_oe & ~sda_o));

	seep_top #(.ADDR_W(AW), .PROG_TIME_NS(2000)) dut (.mclk(mclk), .rst(rst), .ce(ce),
		.link_clk(link_clk), .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
		.write_protect_input(wp), .chip_select_strap_0(strap[0]),
		.chip_select_strap_1(strap[1]), .chip_select_strap_2(strap[2]),
		.write_busy(write_busy));
	seep_bus_master master (.link_clk(link_clk), .sda(sda), .scl(scl), .sda_pull(pull));

	initial
	begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	initial
	begin
		link_clk = 1'b0;
		#1.3;
		forever #3 link_clk = ~link_clk;
	end

	function automatic logic [7:0] sel(input logic rw);
		return {SEL_TYPE, strap, rw};
	endfunction : sel

	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			err_count++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic close_out;
		if (err_count == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : close_out

	task automatic addr_bytes(input int adr);
		// High address byte is don't-care up to 8 address bits, so vary it
		master.xfer((AW > 8) ? 8'(adr >> 8) : 8'($urandom), 1'b1, rx, ack);
		check("addr hi ack", {7'h0, ack}, 8'h00);
		master.xfer(8'(adr), 1'b1, rx, ack);
		check("addr lo ack", {7'h0, ack}, 8'h00);
		ptr = adr % SIZE;
	endtask : addr_bytes

	task automatic open_write(input int adr);
		master.start();
		master.xfer(sel(1'b0), 1'b1, rx, ack);
		check("write select ack", {7'h0, ack}, 8'h00);
		addr_bytes(adr);
	endtask : open_write

	// Read cnt bytes, nack the last, optionally clock one byte more
	task automatic read_run(input int cnt, input logic extra);
		master.start();
		master.xfer(sel(1'b1), 1'b1, rx, ack);
		check("read select ack", {7'h0, ack}, 8'h00);
		for (int i = 0; i < cnt; i++)
		begin
			master.xfer(8'hff, i == cnt - 1, rx, ack);
			check("read data", rx, mem_exp[ptr]);
			ptr = (ptr + 1) % SIZE;
		end
		if (extra)
		begin
			master.xfer(8'hff, 1'b1, rx, ack);
			check("released line", rx, 8'hff);
		end
		master.stop();
	endtask : read_run

	task automatic rand_read(input int adr, input int cnt, input logic extra);
		open_write(adr);
		read_run(cnt, extra);
	endtask : rand_read

	initial
	begin
		#300us;
		err_count++;
		close_out();
	end

	initial
	begin
		rst = 1'b1;
		ce = 1'b1;
		wp = 1'b0;
		err_count = 0;
		total_checks = 0;
		foreach (mem_exp[i]) mem_exp[i] = ERASED_BYTE;
		void'($urandom(32'h0af7));
		strap = 3'($urandom);
		repeat (6) @(posedge mclk);
		rst <= 1'b0;
		master.tick(8);
		// Erased contents, random then current read
		rand_read($urandom % SIZE, 2, 1'b0);
		read_run(1, 1'b0);
		// Foreign type code, then mismatched straps
		for (int k = 0; k < 2; k++)
		begin
			bad = (k == 0) ? {4'hb, strap, 1'b1} : {SEL_TYPE, strap ^ 3'($urandom_range(7, 1)), 1'b1};
			master.start();
			master.xfer(bad, 1'b1, rx, ack);
			check("foreign select nack", {7'h0, ack}, 8'h01);
			master.stop();
		end
		// Four-byte write, then poll until ready
		a = $urandom % 3;
		open_write(a);
		for (int i = 0; i < 4; i++)
		begin
			d = 8'($urandom);
			mem_exp[a + i] = d;
			master.xfer(d, 1'b1, rx, ack);
			check("data ack", {7'h0, ack}, 8'h00);
		end
		master.stop();
		n = 0;
		ack = 1'b1;
		while (ack !== 1'b0 && n < 40)
		begin
			master.start();
			master.xfer(sel(1'b0), 1'b1, rx, ack);
			if (n == 0)
			begin
				check("busy flag", {7'h0, write_busy}, 8'h01);
				check("busy poll nack", {7'h0, ack}, 8'h01);
			end
			n++;
		end
		if (ack !== 1'b0)
		begin
			err_count++;
			close_out();
		end
		addr_bytes(a);
		read_run(2, 1'b1);
		read_run(2, 1'b0);
		// Wrap past the top with write protect high
		wp <= 1'b1;
		rand_read(SIZE - 2, 6, 1'b0);
		wp <= 1'b0;
		// Stop in mid byte must not start a write cycle
		open_write(a);
		master.xfer(~mem_exp[a], 1'b1, rx, ack);
		check("data ack", {7'h0, ack}, 8'h00);
		repeat (3) master.bit_x(1'b0, ack);
		master.stop();
		repeat (100) @(negedge mclk);
		check("no write cycle", {7'h0, write_busy}, 8'h00);
		rand_read(a, 1, 1'b0);
		close_out();
	end
endmodule : tb_serial_eeprom_read_and_busy_poll
`default_nettype wire
